//--- ffs_defs.vh
// Constants for the frame and slice command logic
`ifndef FFS_DEFS_VH
`define FFS_DEFS_VH
`define FFS_FRAME_W      32
`define FFS_SLICE_W      16
`define FFS_TIME_W       24
`define FFS_HIT_W        8
`define FFS_DRAIN_DEPTH  4
`define FFS_DRAIN_AW     2
`define FFS_ZERO_CYCLES  2
`define FFS_METHOD_ZERO  1'b0
`define FFS_METHOD_CAPT  1'b1
`endif

//--- ffs_time_counter.v
// Rollover internal time counter with synchronous zeroing
`timescale 1ns/1ps
`include "ffs_defs.vh"
module ffs_time_counter #(
  parameter TIME_W = 24
) (
  // Clock and reset
  input  wire              clk,
  input  wire              srst,
  // Control
  input  wire              zero_req,
  // Status
  output reg  [TIME_W-1:0] count,
  output reg               zero_busy
);
  reg [1:0] zero_cnt;

  always @(posedge clk) begin
    if (srst) begin
      count     <= {TIME_W{1'b0}};
      zero_cnt  <= 2'h0;
      zero_busy <= 1'b0;
    end else begin
      if (zero_req) begin
        count     <= {TIME_W{1'b0}};
        zero_cnt  <= 2'h0;
        zero_busy <= 1'b1;
      end else begin
        count <= count + {{(TIME_W-1){1'b0}}, 1'b1};
        if (zero_busy) begin
          if (zero_cnt == `FFS_ZERO_CYCLES - 1) begin
            zero_busy <= 1'b0;
            zero_cnt  <= 2'h0;
          end else begin
            zero_cnt <= zero_cnt + 2'h1;
          end
        end
      end
    end
  end
endmodule

//--- ffs_frame_slice_sync.v
// Summary of operation
// - Zeroing method: frame begin with pending loaded zeroes all time counters.
// - Zeroing takes a fixed number of global clocks for this design.
// - Capture method: frame begin latches internal time for the new slice.
// - Accepted frame begin copies pending frame number to current frame.
// - Accepted frame begin marks pending frame register uninitialized.
// - Accepted frame begin sets current slice index to zero.
// - Inactive plus loaded: frame goes active, digitizing and sending start.
// - Active plus unloaded: frame ends, digitizing stops.
// - After a batch ends, already collected hits keep draining out.
// - Inactive plus unloaded: frame begin ignored, no state changes.
// - Slice begin acted on only while frame active.
// - Slice begin: zeroing method nothing; capture method latches time.
// - Accepted slice begin increments slice index by one.
// - Each hit accepted outside zeroing yields counter value, frame index and slice index.
// - Counter goes in block body; frame and slice go in header.
// - Capture method: counter rollover longer than one slice.
// - Zeroing method: rollover covers at least one slice length.
// - Slice index may lead by one; rollover then covers two slices.
// - Load pending command stores number and marks it initialized.
// - Module reset stops all but the time counter, discards data, ignores commands.
// - Internal time counter rolls over to zero after maximum.
`timescale 1ns/1ps
`include "ffs_defs.vh"
module ffs_frame_slice_sync #(
  parameter       METHOD = `FFS_METHOD_ZERO,
  parameter       TIME_W = `FFS_TIME_W
) (
  // Clock and reset
  input  wire                       clk,
  input  wire                       srst,
  // Module reset pin from concentrator
  input  wire                       module_reset_pin,
  // Synchronous commands, one-cycle pulses on clk
  input  wire                       frame_begin_command,
  input  wire                       slice_begin_pulse,
  input  wire                       load_pending_command,
  input  wire [`FFS_FRAME_W-1:0]    load_pending_value,
  // Hit input from discriminator logic
  input  wire                       hit_valid,
  input  wire [`FFS_HIT_W-1:0]      hit_channel,
  // Output data block stream
  output wire                       out_valid,
  input  wire                       out_ready,
  output reg  [`FFS_FRAME_W-1:0]    out_hdr_frame,
  output reg  [`FFS_SLICE_W-1:0]    out_hdr_slice,
  output reg  [TIME_W-1:0]          out_body_time,
  output reg  [`FFS_HIT_W-1:0]      out_body_channel,
  // Status
  output reg                        frame_active,
  output reg                        pending_loaded,
  output reg  [`FFS_FRAME_W-1:0]    pending_frame,
  output reg  [`FFS_FRAME_W-1:0]    current_frame,
  output reg  [`FFS_SLICE_W-1:0]    current_slice,
  output reg  [TIME_W-1:0]          slice_begin_time,
  output wire                       digitize_en,
  output wire                       send_en,
  output wire                       time_zero_busy,
  output wire [TIME_W-1:0]          internal_time
);

  // Pin synchroniser; first stage read by second only
  reg              rst_meta;
  reg              rst_sync;

  // Drain storage for hit records
  reg  [`FFS_FRAME_W-1:0] st_frame [0:`FFS_DRAIN_DEPTH-1];
  reg  [`FFS_SLICE_W-1:0] st_slice [0:`FFS_DRAIN_DEPTH-1];
  reg  [TIME_W-1:0]       st_time  [0:`FFS_DRAIN_DEPTH-1];
  reg  [`FFS_HIT_W-1:0]   st_chan  [0:`FFS_DRAIN_DEPTH-1];
  reg  [`FFS_DRAIN_AW:0]  wr_ptr;
  reg  [`FFS_DRAIN_AW:0]  rd_ptr;
  reg                     out_full_reg;
  reg  [1:0]              batch_state;
  reg  [1:0]              next_batch_state;
  wire                    sending;
  reg                     next_frame_active;
  reg                     next_pending_loaded;
  reg  [`FFS_FRAME_W-1:0] next_pending_frame;
  reg  [`FFS_FRAME_W-1:0] next_current_frame;
  reg  [`FFS_SLICE_W-1:0] next_current_slice;
  reg  [TIME_W-1:0]       next_slice_begin_time;
  reg  [`FFS_DRAIN_AW:0]  next_wr_ptr;
  reg  [`FFS_DRAIN_AW:0]  next_rd_ptr;
  reg                     next_out_full;

  wire                    fifo_empty;
  wire                    fifo_full;
  wire                    fifo_push;
  wire                    fifo_pop;
  wire                    out_take;
  wire                    load_out;
  wire                    accept_frame;
  wire                    end_batch;
  wire                    start_batch;
  wire                    accept_slice;
  wire                    cmd_ok;
  wire                    zero_req;

  function [`FFS_DRAIN_AW-1:0] ffs_idx;
    input [`FFS_DRAIN_AW:0] ptr;
    begin
      ffs_idx = ptr[`FFS_DRAIN_AW-1:0];
    end
  endfunction

  // Pointer step; the extra lap bit tells full from empty
  function [`FFS_DRAIN_AW:0] ffs_ptr_inc;
    input [`FFS_DRAIN_AW:0] ptr;
    begin
      ffs_ptr_inc = ptr + {{`FFS_DRAIN_AW{1'b0}}, 1'b1};
    end
  endfunction

  // Batch states: idle, running, draining after the batch ended
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_RUN   = 2'h1;
  localparam [1:0] ST_DRAIN = 2'h2;

  always @(posedge clk) begin
    if (srst) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
    end else begin
      rst_meta <= module_reset_pin;
      rst_sync <= rst_meta;
    end
  end

  assign cmd_ok = ~rst_sync;

  assign accept_frame = cmd_ok & frame_begin_command & pending_loaded;
  assign end_batch    = cmd_ok & frame_begin_command & ~pending_loaded & frame_active;
  assign start_batch  = accept_frame & ~frame_active;
  assign accept_slice = cmd_ok & slice_begin_pulse & frame_active & ~frame_begin_command;

  assign zero_req = accept_frame & (METHOD == `FFS_METHOD_ZERO);

  ffs_time_counter #(
    .TIME_W (TIME_W)
  ) ffs_time_counter_inst (
    .clk       (clk),
    .srst      (srst),
    .zero_req  (zero_req),
    .count     (internal_time),
    .zero_busy (time_zero_busy)
  );

  // Frame state and indices, next values
  always @* begin
    next_frame_active     = frame_active;
    next_pending_loaded   = pending_loaded;
    next_pending_frame    = pending_frame;
    next_current_frame    = current_frame;
    next_current_slice    = current_slice;
    next_slice_begin_time = slice_begin_time;
    if (rst_sync) begin
      next_frame_active   = 1'b0;
      next_pending_loaded = 1'b0;
    end else begin
      if (accept_frame) begin
        next_current_frame  = pending_frame;
        next_pending_loaded = 1'b0;
        next_current_slice  = {`FFS_SLICE_W{1'b0}};
        if (METHOD == `FFS_METHOD_CAPT) begin
          next_slice_begin_time = internal_time;
        end
        if (start_batch) begin
          next_frame_active = 1'b1;
        end
      end else if (end_batch) begin
        next_frame_active = 1'b0;
      end else if (accept_slice) begin
        next_current_slice = current_slice + {{(`FFS_SLICE_W-1){1'b0}}, 1'b1};
        if (METHOD == `FFS_METHOD_CAPT) begin
          next_slice_begin_time = internal_time;
        end
      end
      // unloaded and inactive leaves state untouched
      // load pending; a same-cycle frame begin consumed old value first
      if (load_pending_command) begin
        next_pending_frame  = load_pending_value;
        next_pending_loaded = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      frame_active     <= 1'b0;
      pending_loaded   <= 1'b0;
      pending_frame    <= {`FFS_FRAME_W{1'b0}};
      current_frame    <= {`FFS_FRAME_W{1'b0}};
      current_slice    <= {`FFS_SLICE_W{1'b0}};
      slice_begin_time <= {TIME_W{1'b0}};
    end else begin
      frame_active     <= next_frame_active;
      pending_loaded   <= next_pending_loaded;
      pending_frame    <= next_pending_frame;
      current_frame    <= next_current_frame;
      current_slice    <= next_current_slice;
      slice_begin_time <= next_slice_begin_time;
    end
  end

  assign digitize_en = frame_active & ~rst_sync;

  // Sending starts with the batch, then stays on to drain
  always @* begin
    next_batch_state = batch_state;
    case (batch_state)
      ST_IDLE: begin
        if (start_batch) begin
          next_batch_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (end_batch) begin
          next_batch_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (start_batch) begin
          next_batch_state = ST_RUN;
        end else if (fifo_empty & ~out_full_reg) begin
          next_batch_state = ST_IDLE;
        end
      end
      default: begin
        next_batch_state = ST_IDLE;
      end
    endcase
    if (rst_sync) begin
      next_batch_state = ST_IDLE;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      batch_state <= ST_IDLE;
    end else begin
      batch_state <= next_batch_state;
    end
  end
  assign sending = (batch_state != ST_IDLE);
  assign send_en = sending & ~rst_sync;

  // one record per hit, all sampled in one cycle
  assign fifo_full  = (wr_ptr[`FFS_DRAIN_AW] != rd_ptr[`FFS_DRAIN_AW]) &
                      (ffs_idx(wr_ptr) == ffs_idx(rd_ptr));
  assign fifo_empty = (wr_ptr == rd_ptr);
  // Hits during zeroing carry an unsettled time, so they are dropped
  assign fifo_push  = hit_valid & digitize_en & ~fifo_full & ~time_zero_busy;
  assign out_take   = out_full_reg & out_ready;
  assign load_out   = ~fifo_empty & send_en & (~out_full_reg | out_ready);
  assign fifo_pop   = load_out;
  assign out_valid  = out_full_reg & send_en;

  // Pointer next values; module reset empties the store
  always @* begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (rst_sync) begin
      next_wr_ptr = {(`FFS_DRAIN_AW+1){1'b0}};
      next_rd_ptr = {(`FFS_DRAIN_AW+1){1'b0}};
    end else begin
      if (fifo_push) begin
        next_wr_ptr = ffs_ptr_inc(wr_ptr);
      end
      if (fifo_pop) begin
        next_rd_ptr = ffs_ptr_inc(rd_ptr);
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      wr_ptr <= {(`FFS_DRAIN_AW+1){1'b0}};
      rd_ptr <= {(`FFS_DRAIN_AW+1){1'b0}};
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always @(posedge clk) begin
    if (fifo_push) begin
      st_frame[ffs_idx(wr_ptr)] <= current_frame;
      st_slice[ffs_idx(wr_ptr)] <= current_slice;
      st_time[ffs_idx(wr_ptr)]  <= internal_time;
      st_chan[ffs_idx(wr_ptr)]  <= hit_channel;
    end
  end

  // Output holding flag; reset flushes a held record
  always @* begin
    next_out_full = out_full_reg;
    if (rst_sync) begin
      next_out_full = 1'b0;
    end else if (load_out) begin
      next_out_full = 1'b1;
    end else if (out_take) begin
      next_out_full = 1'b0;
    end
  end

  // header carries indices, body carries time
  always @(posedge clk) begin
    if (srst) begin
      out_full_reg     <= 1'b0;
      out_hdr_frame    <= {`FFS_FRAME_W{1'b0}};
      out_hdr_slice    <= {`FFS_SLICE_W{1'b0}};
      out_body_time    <= {TIME_W{1'b0}};
      out_body_channel <= {`FFS_HIT_W{1'b0}};
    end else begin
      out_full_reg <= next_out_full;
      if (load_out) begin
        out_hdr_frame    <= st_frame[ffs_idx(rd_ptr)];
        out_hdr_slice    <= st_slice[ffs_idx(rd_ptr)];
        out_body_time    <= st_time[ffs_idx(rd_ptr)];
        out_body_channel <= st_chan[ffs_idx(rd_ptr)];
      end
    end
  end

  // TIME_W must exceed one slice under capture method
  // TIME_W rollover covers a slice under zeroing method
  // slice index is taken at hit time, never late, so one slice suffices
  // relies on concentrator omitting the last pending load
endmodule

//--- ffs_sync_checker.sv
// Assertion checker for frame and slice commands
`timescale 1ns/1ps
`include "ffs_defs.vh"
module ffs_sync_checker #(
  parameter METHOD = 0,
  parameter TIME_W = 24
) (
  // Clock and reset
  input wire                    clk,
  input wire                    srst,
  // Commands
  input wire                    module_reset_pin,
  input wire                    frame_begin_command,
  input wire                    slice_begin_pulse,
  input wire                    load_pending_command,
  input wire [`FFS_FRAME_W-1:0] load_pending_value,
  // Status
  input wire                    frame_active,
  input wire                    pending_loaded,
  input wire [`FFS_FRAME_W-1:0] pending_frame,
  input wire [`FFS_FRAME_W-1:0] current_frame,
  input wire [`FFS_SLICE_W-1:0] current_slice,
  input wire                    digitize_en,
  input wire                    time_zero_busy,
  input wire [TIME_W-1:0]       internal_time,
  input wire [TIME_W-1:0]       slice_begin_time
);
  reg  [2:0] hist;
  wire       ok;
  wire       fb;
  wire       sb;
  // Pin sync lag: trust commands only once pin stayed low
  always @(posedge clk) begin
    if (srst) begin
      hist <= 3'H7;
    end else begin
      hist <= {hist[1:0], module_reset_pin};
    end
  end
  assign ok = (hist == 3'H0) && !module_reset_pin;
  assign fb = ok && frame_begin_command;
  assign sb = ok && slice_begin_pulse && !frame_begin_command;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_load_store: assert property (ok && load_pending_command |=>
    pending_loaded && pending_frame == $past(load_pending_value)) else $error("pending load lost");
  chk_frame_copy: assert property (fb && pending_loaded |=>
    current_frame == $past(pending_frame) && current_slice == 0) else $error("frame copy wrong");
  chk_pend_clear: assert property (fb && pending_loaded && !load_pending_command |=>
    !pending_loaded) else $error("pending not cleared");
  chk_frame_on: assert property (fb && pending_loaded && !frame_active |=>
    frame_active && digitize_en) else $error("frame not started");
  chk_batch_end: assert property (fb && !pending_loaded && frame_active |=>
    !frame_active && !digitize_en) else $error("batch not ended");
  chk_frame_skip: assert property (fb && !pending_loaded && !frame_active |=>
    !frame_active && $stable(current_frame) && $stable(current_slice)) else $error("ignored frame acted");
  chk_slice_step: assert property (sb && frame_active |=>
    current_slice == $past(current_slice) + 16'H1) else $error("slice not incremented");
  chk_slice_drop: assert property (sb && !frame_active |=>
    $stable(current_slice)) else $error("slice counted while inactive");
  chk_zero_time: assert property (METHOD == 0 && fb && pending_loaded |=>
    internal_time == 0 && time_zero_busy ##1 time_zero_busy ##1 !time_zero_busy) else $error("zeroing wrong");
  chk_reset_stop: assert property (module_reset_pin [*4] |=>
    !frame_active && !pending_loaded && !digitize_en) else $error("module reset ignored");
  chk_capt_frame: assert property (METHOD == 1 && fb && pending_loaded |=>
    slice_begin_time == $past(internal_time)) else $error("frame time not captured");
  chk_capt_slice: assert property (METHOD == 1 && sb && frame_active |=>
    slice_begin_time == $past(internal_time)) else $error("slice time not captured");
endmodule

//--- ffs_conc_model.sv
// Concentrator model issuing commands and sinking blocks
`timescale 1ns/1ps
`include "ffs_defs.vh"
module ffs_conc_model (
  // Clock
  input  wire                    clk,
  // Commands and reset line
  output reg                     module_reset_pin,
  output reg                     frame_begin_command,
  output reg                     slice_begin_pulse,
  output reg                     load_pending_command,
  output reg  [`FFS_FRAME_W-1:0] load_pending_value,
  // Block sink
  output reg                     out_ready
);
  initial begin
    {module_reset_pin, frame_begin_command, slice_begin_pulse, load_pending_command, out_ready} = 5'H00;
    load_pending_value = 32'H0;
  end
  // pulses held for n cycles; caller loads before all but last frame
  // Only the strobes named in k are touched, so calls may follow back to back
  task send(input reg [2:0] k, input reg [31:0] v, input integer n);
    begin
      if (k[2]) begin
        load_pending_command = 1'b1;
        load_pending_value = v;
      end
      if (k[1]) slice_begin_pulse = 1'b1;
      if (k[0]) frame_begin_command = 1'b1;
      repeat (n) @(posedge clk);
      #1;
      if (k[2]) begin
        load_pending_command = 1'b0;
        // Idle value line shows junk, not a held number
        load_pending_value = ~v;
      end
      if (k[1]) slice_begin_pulse = 1'b0;
      if (k[0]) frame_begin_command = 1'b0;
    end
  endtask
  task rst(input reg v);
    module_reset_pin = v;
  endtask
  task ready(input reg v);
    out_ready = v;
  endtask
endmodule

//--- tb_ffs_frame_slice_sync.sv
// Testbench for the frame and slice command logic
`timescale 1ns/1ps
`include "ffs_defs.vh"
module tb_ffs_frame_slice_sync;
  reg                     clk = 1'b0;
  reg                     srst = 1'b1;
  reg                     hit_valid = 1'b0;
  reg  [`FFS_HIT_W-1:0]   hit_channel = 8'H00;
  wire                    module_reset_pin, frame_begin_command, slice_begin_pulse, load_pending_command;
  wire                    out_valid, out_ready, frame_active, pending_loaded, digitize_en, send_en, time_zero_busy;
  wire [`FFS_FRAME_W-1:0] load_pending_value, out_hdr_frame, pending_frame, current_frame;
  wire [`FFS_SLICE_W-1:0] out_hdr_slice, current_slice;
  wire [`FFS_TIME_W-1:0]  out_body_time, slice_begin_time, internal_time;
  wire [`FFS_HIT_W-1:0]   out_body_channel;
  integer                 failures = 0;
  integer                 samples_checked = 0;
  integer                 i;
  always #5 clk = ~clk;
  ffs_conc_model ffs_conc_model_inst (.clk, .module_reset_pin, .frame_begin_command, .slice_begin_pulse,
    .load_pending_command, .load_pending_value, .out_ready);
  ffs_frame_slice_sync #(.METHOD(`FFS_METHOD_ZERO), .TIME_W(`FFS_TIME_W)) ffs_frame_slice_sync_inst (.clk, .srst,
    .module_reset_pin, .frame_begin_command, .slice_begin_pulse, .load_pending_command, .load_pending_value,
    .hit_valid, .hit_channel, .out_valid, .out_ready, .out_hdr_frame, .out_hdr_slice, .out_body_time,
    .out_body_channel, .frame_active, .pending_loaded, .pending_frame, .current_frame, .current_slice,
    .slice_begin_time, .digitize_en, .send_en, .time_zero_busy, .internal_time);
  // Second copy built for the capture method, same commands and hits
  wire [`FFS_TIME_W-1:0]  capt_begin_time, capt_time, capt_body_time;
  ffs_frame_slice_sync #(.METHOD(`FFS_METHOD_CAPT), .TIME_W(`FFS_TIME_W)) ffs_frame_slice_sync_capt_inst (.clk,
    .srst, .module_reset_pin, .frame_begin_command, .slice_begin_pulse, .load_pending_command,
    .load_pending_value, .hit_valid, .hit_channel, .out_valid(), .out_ready, .out_hdr_frame(), .out_hdr_slice(),
    .out_body_time(capt_body_time), .out_body_channel(), .frame_active(), .pending_loaded(), .pending_frame(),
    .current_frame(), .current_slice(), .slice_begin_time(capt_begin_time), .digitize_en(), .send_en(),
    .time_zero_busy(), .internal_time(capt_time));
  task check(input reg [31:0] seen, input reg [31:0] exp, input reg [8*8-1:0] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task cmd(input reg [2:0] k, input reg [31:0] v);
    ffs_conc_model_inst.send(k, v, 1);
  endtask
  // Sink stalls until the record is held
  task hit(input reg [7:0] ch);
    begin
      hit_valid = 1'b1;
      hit_channel = ch;
      cyc(1);
      hit_valid = 1'b0;
      for (i = 0; i < 20 && out_valid !== 1'b1; i = i + 1) cyc(1);
    end
  endtask
  task drain;
    begin
      ffs_conc_model_inst.ready(1'b1);
      cyc(1);
      check(out_valid, 1'H0, "drained");
      ffs_conc_model_inst.ready(1'b0);
    end
  endtask
  task t_start;
    begin
      cmd(3'H4, 32'H5);
      check(pending_loaded, 1'H1, "loaded");
      cmd(3'H1, 32'H0);
      check(frame_active, 1'H1, "active");
      check(current_frame, 32'H5, "frame");
      check(pending_loaded, 1'H0, "loaded");
      check(internal_time, 24'H0, "time");
      check(time_zero_busy, 1'H1, "zeroing");
      check(capt_begin_time, 24'H4, "cbegin");
    end
  endtask
  task t_slice;
    begin
      cyc(3);
      // Strobe held up for two back-to-back slice pulses
      ffs_conc_model_inst.send(3'H2, 32'H0, 2);
      check(current_slice, 16'H2, "slice");
      check(slice_begin_time, 24'H0, "zbegin");
      check(capt_begin_time, 24'H9, "cbegin");
      hit(8'HA5);
      check(out_hdr_frame, 32'H5, "hframe");
      check(out_hdr_slice, 16'H2, "hslice");
      check(out_body_channel, 8'HA5, "chan");
      check(out_body_time, 24'H5, "ztime");
      check(capt_body_time, 24'HA, "ctime");
      drain;
    end
  endtask
  task t_next;
    begin
      cmd(3'H4, 32'H6);
      cmd(3'H1, 32'H0);
      check(current_frame, 32'H6, "frame");
      check(current_slice, 16'H0, "slice");
      check(capt_begin_time, 24'HE, "cbegin");
      check(frame_active, 1'H1, "active");
    end
  endtask
  task t_end;
    begin
      cyc(3);
      hit(8'H3C);
      cmd(3'H1, 32'H0);
      check(frame_active, 1'H0, "active");
      check(digitize_en, 1'H0, "digit");
      check(send_en, 1'H1, "sending");
      check(out_valid, 1'H1, "valid");
      drain;
      hit(8'H11);
      check(out_valid, 1'H0, "valid");
      cmd(3'H2, 32'H0);
      check(current_slice, 16'H0, "slice");
      cmd(3'H1, 32'H0);
      check(frame_active, 1'H0, "active");
      check(current_frame, 32'H6, "frame");
    end
  endtask
  task t_reset;
    begin
      cmd(3'H4, 32'H9);
      check(pending_frame, 32'H9, "pending");
      ffs_conc_model_inst.rst(1'b1);
      cyc(4);
      cmd(3'H1, 32'H0);
      check(frame_active, 1'H0, "active");
      check(pending_loaded, 1'H0, "loaded");
      ffs_conc_model_inst.rst(1'b0);
      cyc(3);
      cmd(3'H4, 32'HA);
      cmd(3'H1, 32'H0);
      check(current_frame, 32'HA, "frame");
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    cyc(5);
    srst = 1'b0;
    cyc(3);
    t_start;
    t_slice;
    t_next;
    t_end;
    t_reset;
    results;
  end
  // Run needs about 60 cycles
  initial begin
    #50000;
    failures = failures + 1;
    results;
  end
endmodule
bind ffs_frame_slice_sync ffs_sync_checker #(.METHOD(METHOD), .TIME_W(TIME_W)) ffs_sync_checker_inst (.clk, .srst,
  .module_reset_pin, .frame_begin_command, .slice_begin_pulse, .load_pending_command, .load_pending_value,
  .frame_active, .pending_loaded, .pending_frame, .current_frame, .current_slice, .slice_begin_time, .digitize_en,
  .time_zero_busy, .internal_time);
